/* verilog/coproc_glue_pkg.sv */
// constants shared by the coprocessor bus glue
package coproc_glue_pkg;
    // bus cycle status codes on cycle_status_lines (bits 2..0)
    typedef logic [2:0] cyc_status_t;
    localparam cyc_status_t ST_INT_ACK  = 3'h0;
    localparam cyc_status_t ST_IO_RD    = 3'h1;
    localparam cyc_status_t ST_IO_WR    = 3'h2;
    localparam cyc_status_t ST_HALT     = 3'h3;
    localparam cyc_status_t ST_FETCH    = 3'h4;
    localparam cyc_status_t ST_MEM_RD   = 3'h5;
    localparam cyc_status_t ST_MEM_WR   = 3'h6;
    localparam cyc_status_t ST_PASSIVE  = 3'h7;

    // queue status codes on {queue_state_hi, queue_state_lo}
    typedef logic [1:0] queue_op_t;
    localparam queue_op_t QOP_NONE      = 2'h0;
    localparam queue_op_t QOP_FIRST     = 2'h1;
    localparam queue_op_t QOP_FLUSH     = 2'h2;
    localparam queue_op_t QOP_NEXT      = 2'h3;

    // direction levels: high transmits (write), low receives (read)
    localparam logic DIR_TRANSMIT       = 1'h1;
    localparam logic DIR_RECEIVE        = 1'h0;
    localparam logic DIR_RESET          = 1'h1;
endpackage

/* verilog/coproc_bus_glue.sv */
// coprocessor bus glue: queue status relay, bus strobes, chip select and bus hand-over
`timescale 1ns/100ps

module coproc_bus_glue
    import coproc_glue_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic                          queue_state_lo,
    input  wire logic                          queue_state_hi,
    output logic                               queue_state_lo_out,
    output logic                               queue_state_hi_out,
    input  wire logic                          read_strap_n,
    input  wire coproc_glue_pkg::cyc_status_t  cycle_status_lines,
    output logic                               addr_latch,
    output logic                               read_strobe_n,
    output logic                               write_strobe_n,
    output logic                               data_buffer_enable_n,
    output logic                               transfer_direction,
    input  wire logic                          low_mem_select_n,
    output logic                               select_out_n,
    input  wire logic                          coproc_req_grant_line_in,
    output logic                               coproc_req_grant_line_out,
    output logic                               coproc_req_grant_line_oe,
    input  wire logic                          third_master_req_grant_line_in,
    output logic                               third_master_req_grant_line_out,
    output logic                               third_master_req_grant_line_oe,
    output logic                               host_hold_req,
    input  wire logic                          host_hold_ack,
    input  wire logic                          system_hold_req,
    output logic                               system_hold_ack
);
    import coproc_glue_pkg::*;

    typedef enum logic [1:0] {B_IDLE, B_T1, B_T2} bus_state_t;
    typedef enum logic [2:0] {A_HOST, A_HOLD, A_COPROC, A_T3_REQ, A_T3} arb_state_t;

    bus_state_t  bus_q, bus_d;
    arb_state_t  arb_q, arb_d;
    cyc_status_t cyc_q;
    logic        strap_m_q, strap_s_q, strap_taken_q, queue_mode_q;
    logic        hold_m_q, hold_s_q;
    logic        cp_prev_q, tm_prev_q;
    logic        owns_q, owns_d;
    logic        cp_oe_d, tm_oe_d, hreq_d, sack_d;

    // queue status relay
    // half clock delay
    // code kept whole
    // a falling-edge stage gives exactly half a period without a second clock
    always_ff @(negedge clk_sys) begin
        if (reset) begin
            queue_state_lo_out <= 1'h0;
            queue_state_hi_out <= 1'h0;
        end else begin
            queue_state_lo_out <= queue_state_lo;
            queue_state_hi_out <= queue_state_hi;
        end
    end

    // strap synchroniser runs through reset, so a settled strap is seen as reset ends
    always_ff @(posedge clk_sys) begin
        strap_m_q <= read_strap_n;
        strap_s_q <= strap_m_q;
    end

    // third-master request arrives from off-chip, so it is synchronised
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strap_taken_q <= 1'h0;
            queue_mode_q  <= 1'h0;
            hold_m_q      <= 1'h0;
            hold_s_q      <= 1'h0;
        end else begin
            hold_m_q      <= system_hold_req;
            hold_s_q      <= hold_m_q;
            strap_taken_q <= 1'h1;
            if (!strap_taken_q)
                queue_mode_q <= ~strap_s_q;
        end
    end

    // bus cycle decode
    wire st_active  = (cycle_status_lines != ST_PASSIVE) && (cycle_status_lines != ST_HALT);
    wire cyc_start  = (bus_q == B_IDLE) && queue_mode_q && st_active;
    wire cyc_write  = (cyc_q == ST_IO_WR) || (cyc_q == ST_MEM_WR);
    wire new_write  = (cycle_status_lines == ST_IO_WR) || (cycle_status_lines == ST_MEM_WR);
    wire strobe_on  = (bus_d == B_T2) && (bus_q != B_IDLE);
    wire dir_d      = cyc_start ? (new_write ? DIR_TRANSMIT : DIR_RECEIVE)
                                : transfer_direction;

    always_comb begin
        bus_d = bus_q;
        unique case (bus_q)
            B_IDLE: if (cyc_start) bus_d = B_T1;
            B_T1:   bus_d = B_T2;
            B_T2:   if (!st_active) bus_d = B_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_q                <= B_IDLE;
            cyc_q                <= ST_PASSIVE;
            addr_latch           <= 1'h0;
            read_strobe_n        <= 1'h1;
            write_strobe_n       <= 1'h1;
            data_buffer_enable_n <= 1'h1;
            transfer_direction   <= DIR_RESET;
        end else begin
            bus_q                <= bus_d;
            if (cyc_start)
                cyc_q <= cycle_status_lines;
            addr_latch           <= cyc_start;
            read_strobe_n        <= ~(strobe_on && !cyc_write);
            write_strobe_n       <= ~(strobe_on && cyc_write);
            data_buffer_enable_n <= ~strobe_on;
            transfer_direction   <= dir_d;
        end
    end

    // request/grant pulses: a high-to-low edge the far end drives, never our own drive
    wire cp_pulse = ~coproc_req_grant_line_in & cp_prev_q & ~coproc_req_grant_line_oe;
    wire tm_pulse = ~third_master_req_grant_line_in & tm_prev_q
                    & ~third_master_req_grant_line_oe;

    always_comb begin
        arb_d   = arb_q;
        owns_d  = owns_q;
        cp_oe_d = 1'h0;
        tm_oe_d = 1'h0;
        hreq_d  = host_hold_req;
        sack_d  = system_hold_ack;
        unique case (arb_q)
            A_HOST: if (cp_pulse) begin
                hreq_d = 1'h1;
                arb_d  = A_HOLD;
            end
            A_HOLD: if (host_hold_ack) begin
                cp_oe_d = 1'h1;
                owns_d  = 1'h1;
                arb_d   = A_COPROC;
            end
            A_COPROC: if (cp_pulse) begin
                owns_d = 1'h0;
                hreq_d = 1'h0;
                arb_d  = A_HOST;
            end else if (hold_s_q) begin
                tm_oe_d = 1'h1;
                arb_d   = A_T3_REQ;
            end
            A_T3_REQ: if (tm_pulse) begin
                owns_d = 1'h0;
                sack_d = 1'h1;
                arb_d  = A_T3;
            end
            A_T3: if (!hold_s_q) begin
                sack_d  = 1'h0;
                tm_oe_d = 1'h1;
                owns_d  = 1'h1;
                arb_d   = A_COPROC;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            arb_q                           <= A_HOST;
            owns_q                          <= 1'h0;
            cp_prev_q                       <= 1'h1;
            tm_prev_q                       <= 1'h1;
            coproc_req_grant_line_oe        <= 1'h0;
            coproc_req_grant_line_out       <= 1'h0;
            third_master_req_grant_line_oe  <= 1'h0;
            third_master_req_grant_line_out <= 1'h0;
            host_hold_req                   <= 1'h0;
            system_hold_ack                 <= 1'h0;
            select_out_n                    <= 1'h1;
        end else begin
            arb_q                          <= arb_d;
            owns_q                         <= owns_d;
            cp_prev_q                      <= coproc_req_grant_line_in;
            tm_prev_q                      <= third_master_req_grant_line_in;
            coproc_req_grant_line_oe       <= cp_oe_d;
            third_master_req_grant_line_oe <= tm_oe_d;
            host_hold_req                  <= hreq_d;
            system_hold_ack                <= sack_d;
            select_out_n                   <= low_mem_select_n & ~owns_d;
        end
    end

    // checks
    qs_relay_a: assert property (@(posedge clk_sys) disable iff (reset)
        !$past(reset) |-> {queue_state_hi_out, queue_state_lo_out}
                          == {queue_state_hi, queue_state_lo})
        else $error("queue status not relayed");
    latch_width_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(addr_latch) |=> !addr_latch && (!read_strobe_n || !write_strobe_n))
        else $error("address latch pulse wrong");
    latch_cause_a: assert property (@(posedge clk_sys) disable iff (reset)
        addr_latch |-> $past(queue_mode_q && st_active))
        else $error("latch without valid status");
    strobe_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
        !queue_mode_q |-> read_strobe_n && write_strobe_n && data_buffer_enable_n)
        else $error("strobe outside queue mode");
    dir_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
        $changed(transfer_direction) && !$past(reset) |-> addr_latch)
        else $error("direction changed mid cycle");
    dir_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        addr_latch |-> transfer_direction == ($past(new_write) ? DIR_TRANSMIT : DIR_RECEIVE))
        else $error("direction wrong for cycle");
    select_pass_a: assert property (@(posedge clk_sys) disable iff (reset)
        !$past(low_mem_select_n) && !$past(reset) |-> !select_out_n)
        else $error("select not passed");
    select_own_a: assert property (@(posedge clk_sys) disable iff (reset)
        owns_q |-> !select_out_n)
        else $error("select not forced");
    grant_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        arb_q == A_HOLD && host_hold_ack |=> coproc_req_grant_line_oe && owns_q ##1
        !coproc_req_grant_line_oe)
        else $error("grant pulse missing");
    release_own_a: assert property (@(posedge clk_sys) disable iff (reset)
        arb_q == A_COPROC && cp_pulse |=> !owns_q && !host_hold_req)
        else $error("release not honoured");
    third_back_a: assert property (@(posedge clk_sys) disable iff (reset)
        arb_q == A_T3 && !hold_s_q |=> third_master_req_grant_line_oe && owns_q
        && !system_hold_ack)
        else $error("third master return wrong");

    read_cycle_c: cover property (@(posedge clk_sys) disable iff (reset)
        addr_latch ##1 !read_strobe_n);
    write_cycle_c: cover property (@(posedge clk_sys) disable iff (reset)
        addr_latch ##1 !write_strobe_n);
    coproc_own_c: cover property (@(posedge clk_sys) disable iff (reset)
        arb_q == A_COPROC ##[1:50] arb_q == A_HOST);
    third_trip_c: cover property (@(posedge clk_sys) disable iff (reset)
        arb_q == A_T3 ##[1:50] arb_q == A_COPROC);
endmodule

/* verif/coproc_bus_partner.sv */
// far-side model: host hold acknowledge, coprocessor queue mirror and hand-over pulses
`timescale 1ns/100ps
module coproc_bus_partner
    import coproc_glue_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [1:0] queue_code,
    input  wire logic       host_hold_req,
    output logic            host_hold_ack,
    output logic            cp_line_oe,
    output logic            tm_line_oe
);
    int ack_delay = 2;
    int wait_n    = 0;
    initial begin
        host_hold_ack = 1'b0;
        cp_line_oe    = 1'b0;
        tm_line_oe    = 1'b0;
    end
    // coprocessor queue mirror, run from the relayed status
    logic [7:0] fifo [8];
    int         wr_p   = 0;
    int         rd_p   = 0;
    bit         esc_q  = 1'b0;
    int         esc_n  = 0;
    int         dec_n  = 0;
    int         disc_n = 0;
    task automatic fetch(input logic [7:0] b);
        fifo[wr_p % 8] = b;
        wr_p++;
    endtask
    always @(posedge clk_sys) begin
        if (queue_code == QOP_FIRST) begin
            esc_q = fifo[rd_p % 8][7:3] == 5'b11011;
            if (esc_q)
                esc_n++;
            rd_p++;
        end else if (queue_code == QOP_NEXT) begin
            if (esc_q)
                dec_n++;
            else
                disc_n++;
            rd_p++;
        end else if (queue_code == QOP_FLUSH) begin
            rd_p = wr_p;
        end
    end
    always @(posedge clk_sys) begin
        if (!host_hold_req) begin
            host_hold_ack <= 1'b0;
            wait_n        <= 0;
        end else if (wait_n >= ack_delay) begin
            host_hold_ack <= 1'b1;
        end else begin
            wait_n <= wait_n + 1;
        end
    end
    // one-cycle low pulse: request, release or grant; open drain, so only the enable moves
    // two idle clocks first keep it from merging with a pulse the glue has just sent
    task automatic pulse(input bit third);
        repeat (2) @(posedge clk_sys);
        cp_line_oe <= !third;
        tm_line_oe <= third;
        @(posedge clk_sys);
        cp_line_oe <= 1'b0;
        tm_line_oe <= 1'b0;
    endtask
endmodule

/* verif/tb_coproc_bus_glue.sv */
// self-checking bench for the coprocessor bus glue
`timescale 1ns/100ps
module tb_coproc_bus_glue;
    import coproc_glue_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        q_lo = 1'b0, q_hi = 1'b0, sel_in_n = 1'b1, sys_req = 1'b0;
    logic        strap_n = 1'b0;
    cyc_status_t status = ST_PASSIVE;
    logic        q_lo_o, q_hi_o, latch_o, rd_n, wr_n, data_en_n, dir, sel_n;
    logic        cp_out, cp_oe, tm_out, tm_oe, hold_req, hold_ack, sys_ack, p_cp_oe, p_tm_oe;
    // pull-up lines: low whenever either party enables its driver
    wire         cp_line = (cp_oe ? cp_out : 1'b1) & !p_cp_oe;
    wire         tm_line = (tm_oe ? tm_out : 1'b1) & !p_tm_oe;
    wire  [3:0]  mon = {sys_ack, tm_oe, cp_oe, hold_req};
    int          n_errors = 0;
    int          samples_checked = 0;
    always #2.5 clk_sys = !clk_sys;
    coproc_bus_glue dut_u (.clk_sys(clk_sys), .reset(reset), .queue_state_lo(q_lo),
        .queue_state_hi(q_hi), .queue_state_lo_out(q_lo_o), .queue_state_hi_out(q_hi_o),
        .read_strap_n(strap_n), .cycle_status_lines(status), .addr_latch(latch_o),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_buffer_enable_n(data_en_n),
        .transfer_direction(dir), .low_mem_select_n(sel_in_n), .select_out_n(sel_n),
        .coproc_req_grant_line_in(cp_line), .coproc_req_grant_line_out(cp_out),
        .coproc_req_grant_line_oe(cp_oe), .third_master_req_grant_line_in(tm_line),
        .third_master_req_grant_line_out(tm_out), .third_master_req_grant_line_oe(tm_oe),
        .host_hold_req(hold_req), .host_hold_ack(hold_ack), .system_hold_req(sys_req),
        .system_hold_ack(sys_ack));
    coproc_bus_partner part_u (.clk_sys(clk_sys), .queue_code({q_hi_o, q_lo_o}),
        .host_hold_req(hold_req), .host_hold_ack(hold_ack), .cp_line_oe(p_cp_oe),
        .tm_line_oe(p_tm_oe));
    task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // bounded wait on one monitored output
    task automatic wait_bit(input int idx, input logic val);
        int i;
        for (i = 0; i < 20 && mon[idx] !== val; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk($sformatf("wait on bit %0d", idx), {1'b0, val}, {1'b0, mon[idx]});
    endtask
    task automatic test_queue;
        queue_op_t codes [6] = '{QOP_FIRST, QOP_NEXT, QOP_FIRST, QOP_NEXT,
                                 QOP_FLUSH, QOP_NONE};
        queue_op_t prev = QOP_NONE;
        part_u.fetch(8'hD9);
        part_u.fetch(8'h12);
        part_u.fetch(8'hC9);
        part_u.fetch(8'h34);
        foreach (codes[k]) begin
            @(posedge clk_sys);
            {q_hi, q_lo} <= codes[k];
            #1;
            chk("queue before half clock", prev, {q_hi_o, q_lo_o});
            @(negedge clk_sys);
            #1;
            chk("queue relayed", codes[k], {q_hi_o, q_lo_o});
            prev = codes[k];
        end
        @(posedge clk_sys);
        #1;
        chk("escape bytes", 2'h1, 2'(part_u.esc_n));
        chk("bytes decoded", 2'h1, 2'(part_u.dec_n));
        chk("bytes discarded", 2'h1, 2'(part_u.disc_n));
        chk("queue flushed", 2'h0, 2'(part_u.wr_p - part_u.rd_p));
        $display("test queue relay done");
    endtask
    task automatic bus_cycle(input cyc_status_t st, input logic wr);
        @(posedge clk_sys);
        status <= st;
        @(posedge clk_sys);
        #1;
        chk("addr latch start", 2'h1, latch_o);
        chk("direction at start", wr, dir);
        @(posedge clk_sys);
        status <= ST_PASSIVE;
        #1;
        chk("addr latch end", 2'h0, latch_o);
        chk("read write strobes", {!wr, wr}, {wr_n, rd_n});
        chk("data enable", 2'h0, data_en_n);
        chk("direction mid cycle", wr, dir);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("strobes idle", 2'h3, {wr_n, rd_n});
        chk("direction held idle", wr, dir);
    endtask
    task automatic test_bus;
        chk("direction after reset", DIR_RESET, dir);
        chk("strobes after reset", 2'h3, {wr_n, rd_n});
        bus_cycle(ST_MEM_RD, DIR_RECEIVE);
        bus_cycle(ST_IO_RD, DIR_RECEIVE);
        bus_cycle(ST_MEM_WR, DIR_TRANSMIT);
        bus_cycle(ST_IO_WR, DIR_TRANSMIT);
        bus_cycle(ST_FETCH, DIR_RECEIVE);
        bus_cycle(ST_INT_ACK, DIR_RECEIVE);
        @(posedge clk_sys);
        status <= ST_HALT;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("halt starts no cycle", 2'h0, latch_o);
        @(posedge clk_sys);
        status <= ST_PASSIVE;
        $display("test bus strobes done");
    endtask
    task automatic test_select;
        @(posedge clk_sys);
        sel_in_n <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("select follows", 2'h0, sel_n);
        @(posedge clk_sys);
        sel_in_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("select released", 2'h1, sel_n);
        $display("test select pass done");
    endtask
    task automatic test_handover;
        part_u.ack_delay = 4;
        part_u.pulse(1'b0);
        wait_bit(0, 1'b1);
        wait_bit(1, 1'b1);
        chk("select while owned", 2'h0, sel_n);
        chk("grant line level", 2'h0, cp_line);
        @(posedge clk_sys);
        sys_req <= 1'b1;
        #1;
        chk("grant lasts one cycle", 2'h0, cp_oe);
        wait_bit(2, 1'b1);
        chk("request line level", 2'h0, tm_line);
        part_u.pulse(1'b1);
        wait_bit(3, 1'b1);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("select freed for third", 2'h1, sel_n);
        @(posedge clk_sys);
        sys_req <= 1'b0;
        wait_bit(2, 1'b1);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("select back to coproc", 2'h0, sel_n);
        part_u.pulse(1'b0);
        wait_bit(0, 1'b0);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("select after release", 2'h1, sel_n);
        $display("test bus hand-over done");
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        test_queue();
        test_bus();
        test_select();
        test_handover();
        give_verdict();
    end
    // tests need about a hundred cycles; a hang ends here
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_errors++;
        give_verdict();
    end
endmodule
